/* verilog/serial_port_protocol_engine.sv */
// Per-port protocol engine: packet forming, routes, host translation, auto-transfer
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "serial_engine_defines.svh"
// Contract
// - Size limit closes packet, default 128
// - Size one sends each character alone
// - Inter-character gap closes packet, default 100
// - Enabled control character closes packet early
// - Echo returns received characters when enabled
// - Gateway highlight wraps returned messages
// - Error check selects block check or CRC
// - Final drop 205 replaced by appendix
// - Replacement uses appendix, reply route reversed
// - Option bit 2 maps 205,X via table
// - Multidrop waits time slice after network activity
// - Reads map to function 1,2,3,4
// - Writes map to function 5,6,15,16
// - Retry timeout spaces failed transmission retries
// - Address equals register plus bias minus one
// - Auto-transfer fires every configured interval
// - Read count zero disables, else consecutive
// - Read data stored from mailbox destination
// - Write count zero disables, else consecutive
// - Write data taken from mailbox source
module serial_port_protocol_engine #(
    parameter int TICK_CYCLES = `CLK_HZ / `TICK_HZ
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             pkt_valid,
    output logic      [7:0]  pkt_data,
    output logic             pkt_close,
    input  wire logic        ret_valid,
    input  wire logic [7:0]  ret_data,
    input  wire logic        ret_last,
    output logic             ret_ready,
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    output logic             crc_sel,
    input  wire logic        rin_valid,
    input  wire logic [3:0]  rin_len,
    input  wire logic [63:0] rin_route,
    output logic             rout_valid,
    output logic      [3:0]  rout_len,
    output logic      [63:0] rout_route,
    output logic      [3:0]  reply_len,
    output logic      [63:0] reply_route,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [13:0] req_reg,
    output logic             mb_valid,
    output logic      [7:0]  mb_func,
    output logic      [15:0] mb_addr,
    input  wire logic        mb_fail,
    output logic             retry_go,
    input  wire logic        net_activity,
    output logic             md_clear,
    output logic             at_rd_valid,
    output logic      [15:0] at_rd_reg,
    output logic      [15:0] at_rd_cnt,
    output logic             at_wr_valid,
    output logic      [15:0] at_wr_reg,
    output logic      [15:0] at_wr_cnt,
    input  wire logic        at_rd_data_valid,
    input  wire logic [15:0] at_rd_data,
    output logic             mbx_we,
    output logic      [15:0] mbx_waddr,
    output logic      [15:0] mbx_wdata,
    input  wire logic        at_wr_data_req,
    output logic      [15:0] mbx_raddr
);
    logic [20:0] tdiv_ff, nxt_tdiv;
    logic        tick;
    logic [31:0] cfg_ff [0:`NUM_CFG-1];
    logic [31:0] nxt_cfg [0:`NUM_CFG-1];
    logic [31:0] rdat_ff, nxt_rdat;
    logic        ack_ff, nxt_ack;
    logic [63:0] tbl_ff [0:127];
    logic [3:0]  tbl_len_ff [0:127];
    logic [15:0] held_ff, nxt_held;
    logic        pv_ff, nxt_pv, pc_ff, nxt_pc;
    logic [7:0]  pd_ff, nxt_pd;
    serial_engine_pkg::hl_state_t hl_ff, nxt_hl;
    logic [1:0]  seq_ff, nxt_seq;
    logic        hlmsg_ff, nxt_hlmsg, epend_ff, nxt_epend, txv_ff, nxt_txv;
    logic [7:0]  ech_ff, nxt_ech, txd_ff, nxt_txd;
    logic        rv_ff, nxt_rv;
    logic [3:0]  rl_ff, nxt_rl, pl_ff, nxt_pl;
    logic [63:0] rr_ff, nxt_rr, pr_ff, nxt_pr;
    logic        mbv_ff, nxt_mbv, rpend_ff, nxt_rpend, rgo_ff, nxt_rgo;
    logic [7:0]  mbf_ff, nxt_mbf;
    logic [15:0] mba_ff, nxt_mba;
    logic        net_s1_ff, net_s2_ff, mdc_ff;
    logic        arv_ff, nxt_arv, awv_ff, nxt_awv, mwe_ff, nxt_mwe;
    logic [15:0] ridx_ff, nxt_ridx, widx_ff, nxt_widx, mwa_ff, nxt_mwa;
    logic [15:0] mwd_ff, nxt_mwd, mra_ff, nxt_mra;
    logic        gap_exp, slice_exp, retry_exp, at_fire, fire_ff;
    serial_engine_pkg::port_mode_t mode;
    logic        pkt_mode, wb_req, wb_wr;
    logic [3:0]  widx_w, appx_len;
    logic [63:0] appx;

    assign mode = serial_engine_pkg::port_mode_t'(cfg_ff[`RI_MODE][2:0]);
    assign pkt_mode = mode == serial_engine_pkg::MODE_TRANSP ||
                      mode == serial_engine_pkg::MODE_SHARE ||
                      mode == serial_engine_pkg::MODE_GATE;
    assign appx_len = cfg_ff[`RI_APPX_LEN][3:0];
    assign appx = {cfg_ff[`RI_APPX_HI], cfg_ff[`RI_APPX_LO]};

    // Hundredth-of-a-second tick
    assign tick = tdiv_ff == 21'(TICK_CYCLES - 1);
    always_comb nxt_tdiv = tick ? 21'h000000 : tdiv_ff + 21'h000001;

    // Wishbone slave: ack one cycle after request, write at the acked edge
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[8*i +: 8] = n[8*i +: 8];
        end
        return r;
    endfunction

    function automatic logic [31:0] cfg_rst(input int i);
        case (i)
            0:       return `RST_MODE;
            1:       return `RST_PKT;
            2:       return `RST_MB;
            3:       return `RST_BIAS;
            default: return 32'h00000000;
        endcase
    endfunction

    assign widx_w = wb_adr_i[5:2];
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wb_wr = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_adr_i[7:6] == 2'b00;

    always_comb begin
        logic [31:0] m;
        m = 32'h00000000;
        nxt_ack = wb_req;
        nxt_rdat = 32'h00000000;
        for (int i = 0; i < `NUM_CFG; i++) nxt_cfg[i] = cfg_ff[i];
        if (wb_req && !wb_we_i && wb_adr_i[7:6] == 2'b00) begin
            if (widx_w == `RI_STATUS) nxt_rdat = {14'h0000, mdc_ff, rpend_ff, held_ff};
            else nxt_rdat = cfg_ff[widx_w];
        end
        if (wb_wr && widx_w != `RI_STATUS) begin
            m = merge(cfg_ff[widx_w], wb_dat_i, wb_sel_i);
            if (widx_w == `RI_MB) begin
                if (m[7:0] < 8'h01 || m[7:0] > 8'h04) m[7:0] = cfg_ff[`RI_MB][7:0];
                if (!(m[15:8] == 8'h05 || m[15:8] == 8'h06 || m[15:8] == 8'h0f ||
                      m[15:8] == 8'h10)) m[15:8] = cfg_ff[`RI_MB][15:8];
            end
            nxt_cfg[widx_w] = m;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wb_wr && widx_w == `RI_TBL_HI) begin
            tbl_ff[cfg_ff[`RI_TBL_IDX][6:0]] <= {merge(32'h00000000, wb_dat_i, wb_sel_i),
                                                 cfg_ff[`RI_TBL_LO]};
            tbl_len_ff[cfg_ff[`RI_TBL_IDX][6:0]] <= cfg_ff[`RI_TBL_IDX][11:8];
        end
    end

    // Packet forming
    gap_timer #(.W(16)) u_gap (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick    (tick),
        .restart (rx_valid),
        .run     (pkt_mode && held_ff != 16'h0000),
        .limit   (cfg_ff[`RI_PKT][31:16]),
        .expired (gap_exp)
    );

    always_comb begin
        nxt_held = held_ff;
        nxt_pv = 1'b0;
        nxt_pd = pd_ff;
        nxt_pc = 1'b0;
        if (!pkt_mode) begin
            nxt_held = 16'h0000;
        end else if (rx_valid) begin
            nxt_pv = 1'b1;
            nxt_pd = rx_data;
            if (held_ff + 16'h0001 >= cfg_ff[`RI_PKT][15:0]) begin
                nxt_pc = 1'b1;
                nxt_held = 16'h0000;
            end else if (cfg_ff[`RI_MODE][`CTL_CHAR_BIT] && rx_data <= `CTL_CHAR_MAX) begin
                nxt_pc = 1'b1;
                nxt_held = 16'h0000;
            end else begin
                nxt_held = held_ff + 16'h0001;
            end
        end else if (gap_exp) begin
            nxt_pc = 1'b1;
            nxt_held = 16'h0000;
        end
    end

    // Transmit side: echo and highlighted returned messages
    assign ret_ready = hl_ff == serial_engine_pkg::HL_BODY && (!txv_ff || tx_ready);

    always_comb begin
        logic free;
        free = !txv_ff || tx_ready;
        nxt_hl = hl_ff;
        nxt_seq = seq_ff;
        nxt_hlmsg = hlmsg_ff;
        nxt_epend = epend_ff;
        nxt_ech = ech_ff;
        nxt_txv = txv_ff && !tx_ready;
        nxt_txd = txd_ff;
        unique case (hl_ff)
            serial_engine_pkg::HL_IDLE: begin
                if (free && epend_ff) begin
                    nxt_txv = 1'b1;
                    nxt_txd = ech_ff;
                    nxt_epend = 1'b0;
                end else if (free && ret_valid) begin
                    nxt_hlmsg = cfg_ff[`RI_MODE][`HILITE_BIT] &&
                                mode == serial_engine_pkg::MODE_GATE;
                    nxt_hl = nxt_hlmsg ? serial_engine_pkg::HL_PRE
                                       : serial_engine_pkg::HL_BODY;
                    nxt_seq = 2'h0;
                end
            end
            serial_engine_pkg::HL_PRE: begin
                if (free) begin
                    nxt_txv = 1'b1;
                    nxt_txd = 8'(`HL_ON_SEQ >> {~seq_ff, 3'b000});
                    nxt_seq = seq_ff + 2'h1;
                    if (seq_ff == 2'h3) nxt_hl = serial_engine_pkg::HL_BODY;
                end
            end
            serial_engine_pkg::HL_BODY: begin
                if (free && ret_valid) begin
                    nxt_txv = 1'b1;
                    nxt_txd = ret_data;
                    if (ret_last) nxt_hl = hlmsg_ff ? serial_engine_pkg::HL_POST
                                                    : serial_engine_pkg::HL_IDLE;
                end
            end
            serial_engine_pkg::HL_POST: begin
                if (free) begin
                    nxt_txv = 1'b1;
                    nxt_txd = 8'(`HL_OFF_SEQ >> {~seq_ff, 3'b000});
                    nxt_seq = seq_ff + 2'h1;
                    if (seq_ff == 2'h3) nxt_hl = serial_engine_pkg::HL_IDLE;
                end
            end
            default: nxt_hl = serial_engine_pkg::HL_IDLE;
        endcase
        if (rx_valid && pkt_mode && cfg_ff[`RI_MODE][`ECHO_BIT]) begin
            nxt_epend = 1'b1;
            nxt_ech = rx_data;
        end
    end

    // Route appendix, replacement and table lookup
    always_comb begin
        logic [3:0] j, keep, k;
        logic [7:0] last;
        {j, k} = 8'h00;
        nxt_rv = rin_valid;
        nxt_rl = rl_ff;
        nxt_rr = rr_ff;
        nxt_pl = pl_ff;
        nxt_pr = pr_ff;
        keep = rin_len - 4'h1;
        last = rin_route[{keep[2:0], 3'b000} +: 8];
        if (rin_valid) begin
            nxt_rl = rin_len;
            nxt_rr = rin_route;
            nxt_pl = rin_len;
            for (int i = 0; i < 8; i++) begin
                j = rin_len - 4'(i) - 4'h1;
                nxt_pr[8*i +: 8] = (4'(i) < rin_len) ? rin_route[{j[2:0], 3'b000} +: 8]
                                                     : 8'h00;
            end
            if (mode == serial_engine_pkg::MODE_LEGACY) begin
                if (cfg_ff[`RI_MODE][`OPT_TABLE_BIT] && rin_len == 4'h2 &&
                    rin_route[7:0] == `ROUTE_EXT_DROP && !rin_route[15]) begin
                    nxt_rr = tbl_ff[rin_route[14:8]];
                    nxt_rl = tbl_len_ff[rin_route[14:8]];
                    nxt_pr = {48'h000000000000, `ROUTE_EXT_DROP, rin_route[15:8]};
                end else if (cfg_ff[`RI_MODE][`REPLACE_BIT]) begin
                    nxt_rr = appx;
                    nxt_rl = appx_len;
                end else if (appx_len != 4'h0 && rin_len != 4'h0 &&
                             last == `ROUTE_EXT_DROP) begin
                    for (int i = 0; i < 8; i++) begin
                        k = 4'(i) - keep;
                        if (4'(i) < keep) nxt_rr[8*i +: 8] = rin_route[8*i +: 8];
                        else if (k < appx_len) nxt_rr[8*i +: 8] = appx[{k[2:0], 3'b000} +: 8];
                        else nxt_rr[8*i +: 8] = 8'h00;
                    end
                    nxt_rl = (keep + appx_len > 4'h8) ? 4'h8 : keep + appx_len;
                end
            end
        end
    end

    // Host function translation and retries
    gap_timer #(.W(16)) u_retry (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick    (tick),
        .restart (mb_fail),
        .run     (rpend_ff),
        .limit   (cfg_ff[`RI_MB][31:16]),
        .expired (retry_exp)
    );

    always_comb begin
        nxt_mbv = req_valid && mode == serial_engine_pkg::MODE_MBHOST &&
                  req_reg != 14'h0000 && req_reg <= `LEG_REG_MAX;
        nxt_mbf = mbf_ff;
        nxt_mba = mba_ff;
        if (nxt_mbv) begin
            nxt_mbf = req_write ? cfg_ff[`RI_MB][15:8] : cfg_ff[`RI_MB][7:0];
            nxt_mba = 16'({2'b00, req_reg} + cfg_ff[`RI_BIAS][15:0] - 16'h0001);
        end
        nxt_rgo = retry_exp;
        nxt_rpend = rpend_ff && !retry_exp;
        if (mb_fail && (mode == serial_engine_pkg::MODE_MBHOST ||
                        mode == serial_engine_pkg::MODE_MBGATE)) nxt_rpend = 1'b1;
    end

    // Multidrop time slice after last network activity
    gap_timer #(.W(16)) u_slice (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick    (tick),
        .restart (net_s2_ff),
        .run     (mode == serial_engine_pkg::MODE_MDROP),
        .limit   (cfg_ff[`RI_SLICE][15:0]),
        .expired (slice_exp)
    );

    // Auto-transfer
    gap_timer #(.W(16)) u_ival (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick    (tick),
        .restart (fire_ff),
        .run     (cfg_ff[`RI_IVAL][15:0] != 16'h0000),
        .limit   (cfg_ff[`RI_IVAL][15:0]),
        .expired (at_fire)
    );

    always_comb begin
        nxt_arv = at_fire && cfg_ff[`RI_RD][15:0] != 16'h0000;
        nxt_awv = at_fire && cfg_ff[`RI_WR][15:0] != 16'h0000;
        nxt_ridx = at_fire ? 16'h0000 : ridx_ff;
        nxt_widx = at_fire ? 16'h0000 : widx_ff;
        nxt_mwe = 1'b0;
        nxt_mwa = mwa_ff;
        nxt_mwd = mwd_ff;
        nxt_mra = mra_ff;
        if (at_rd_data_valid && !at_fire) begin
            nxt_mwe = 1'b1;
            nxt_mwa = cfg_ff[`RI_XFER][15:0] + ridx_ff;
            nxt_mwd = at_rd_data;
            nxt_ridx = ridx_ff + 16'h0001;
        end
        if (at_wr_data_req && !at_fire) begin
            nxt_mra = cfg_ff[`RI_XFER][31:16] + widx_ff;
            nxt_widx = widx_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tdiv_ff <= 21'h000000;
            for (int i = 0; i < `NUM_CFG; i++) cfg_ff[i] <= cfg_rst(i);
            {rdat_ff, ack_ff} <= {32'h00000000, 1'b0};
            {held_ff, pv_ff, pd_ff, pc_ff} <= {16'h0000, 1'b0, 8'h00, 1'b0};
            hl_ff <= serial_engine_pkg::HL_IDLE;
            {seq_ff, hlmsg_ff, epend_ff, ech_ff, txv_ff, txd_ff} <= '0;
            {rv_ff, rl_ff, rr_ff, pl_ff, pr_ff} <= '0;
            {mbv_ff, mbf_ff, mba_ff, rpend_ff, rgo_ff, fire_ff} <= '0;
            {net_s1_ff, net_s2_ff, mdc_ff} <= 3'h0;
            {arv_ff, awv_ff, ridx_ff, widx_ff} <= '0;
            {mwe_ff, mwa_ff, mwd_ff, mra_ff} <= '0;
        end else begin
            tdiv_ff <= nxt_tdiv;
            for (int i = 0; i < `NUM_CFG; i++) cfg_ff[i] <= nxt_cfg[i];
            {rdat_ff, ack_ff} <= {nxt_rdat, nxt_ack};
            {held_ff, pv_ff, pd_ff, pc_ff} <= {nxt_held, nxt_pv, nxt_pd, nxt_pc};
            hl_ff <= nxt_hl;
            {seq_ff, hlmsg_ff, epend_ff, ech_ff} <= {nxt_seq, nxt_hlmsg, nxt_epend, nxt_ech};
            {txv_ff, txd_ff} <= {nxt_txv, nxt_txd};
            {rv_ff, rl_ff, rr_ff, pl_ff, pr_ff} <= {nxt_rv, nxt_rl, nxt_rr, nxt_pl, nxt_pr};
            {mbv_ff, mbf_ff, mba_ff} <= {nxt_mbv, nxt_mbf, nxt_mba};
            {rpend_ff, rgo_ff, fire_ff} <= {nxt_rpend, nxt_rgo, at_fire};
            net_s1_ff <= net_activity;
            net_s2_ff <= net_s1_ff;
            mdc_ff <= slice_exp;
            {arv_ff, awv_ff, ridx_ff, widx_ff} <= {nxt_arv, nxt_awv, nxt_ridx, nxt_widx};
            {mwe_ff, mwa_ff, mwd_ff, mra_ff} <= {nxt_mwe, nxt_mwa, nxt_mwd, nxt_mra};
        end
    end

    assign wb_dat_o = rdat_ff;
    assign wb_ack_o = ack_ff;
    assign {pkt_valid, pkt_data, pkt_close} = {pv_ff, pd_ff, pc_ff};
    assign {tx_valid, tx_data} = {txv_ff, txd_ff};
    assign crc_sel = cfg_ff[`RI_MODE][`CRC_BIT];
    assign {rout_valid, rout_len, rout_route} = {rv_ff, rl_ff, rr_ff};
    assign {reply_len, reply_route} = {pl_ff, pr_ff};
    assign {mb_valid, mb_func, mb_addr} = {mbv_ff, mbf_ff, mba_ff};
    assign retry_go = rgo_ff;
    assign md_clear = mdc_ff;
    assign at_rd_valid = arv_ff;
    assign at_rd_reg = cfg_ff[`RI_RD][31:16];
    assign at_rd_cnt = cfg_ff[`RI_RD][15:0];
    assign at_wr_valid = awv_ff;
    assign at_wr_reg = cfg_ff[`RI_WR][31:16];
    assign at_wr_cnt = cfg_ff[`RI_WR][15:0];
    assign {mbx_we, mbx_waddr, mbx_wdata} = {mwe_ff, mwa_ff, mwd_ff};
    assign mbx_raddr = mra_ff;
endmodule

/* verilog/serial_engine_defines.svh */
// Register indices, field positions, reset values and timing constants
`ifndef SERIAL_ENGINE_DEFINES_SVH
`define SERIAL_ENGINE_DEFINES_SVH

`define CLK_HZ          125000000
`define TICK_HZ         100

`define RI_MODE         4'h0
`define RI_PKT          4'h1
`define RI_MB           4'h2
`define RI_BIAS         4'h3
`define RI_SLICE        4'h4
`define RI_IVAL         4'h5
`define RI_RD           4'h6
`define RI_XFER         4'h7
`define RI_WR           4'h8
`define RI_APPX_LEN     4'h9
`define RI_APPX_LO      4'ha
`define RI_APPX_HI      4'hb
`define RI_TBL_IDX      4'hc
`define RI_TBL_LO       4'hd
`define RI_TBL_HI       4'he
`define RI_STATUS       4'hf
`define NUM_CFG         15

`define CTL_CHAR_BIT    8
`define ECHO_BIT        9
`define HILITE_BIT      10
`define CRC_BIT         11
`define REPLACE_BIT     12
`define OPT_TABLE_BIT   18

`define RST_MODE        32'h00000100
`define RST_PKT         32'h00640080
`define RST_MB          32'h00641004
`define RST_BIAS        32'h00000001

`define ROUTE_EXT_DROP  8'hcd
`define CTL_CHAR_MAX    8'h1f
`define HL_ON_SEQ       32'h1b5b376d
`define HL_OFF_SEQ      32'h1b5b306d
`define LEG_REG_MAX     14'h2000

`endif

/* verilog/serial_engine_pkg.sv */
// Types shared by the serial port protocol engine
package serial_engine_pkg;
    typedef enum logic [2:0] {
        MODE_TRANSP = 3'h0,
        MODE_SHARE  = 3'h1,
        MODE_GATE   = 3'h2,
        MODE_MDROP  = 3'h3,
        MODE_MBHOST = 3'h4,
        MODE_MBGATE = 3'h5,
        MODE_LEGACY = 3'h6
    } port_mode_t;

    typedef enum logic [3:0] {
        HL_IDLE = 4'b0001,
        HL_PRE  = 4'b0010,
        HL_BODY = 4'b0100,
        HL_POST = 4'b1000
    } hl_state_t;
endpackage

/* verilog/gap_timer.sv */
// Tick counter with restart and limit compare
`timescale 1ns/1ps
module gap_timer #(
    parameter int W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         tick,
    input  wire logic         restart,
    input  wire logic         run,
    input  wire logic [W-1:0] limit,
    output logic              expired
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (restart || !run) begin
            nxt_cnt = '0;
        end else if (tick && cnt_ff != {W{1'b1}}) begin
            nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign expired = run && !restart && (cnt_ff >= limit);
endmodule

/* sim/serial_engine_assertions.sv */
// Port checks for the protocol engine
`timescale 1ns/1ps
module serial_engine_assertions (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic       pkt_valid,
    input wire logic [7:0] pkt_data,
    input wire logic       pkt_close,
    input wire logic       req_valid,
    input wire logic       mb_valid,
    input wire logic       rin_valid,
    input wire logic       rout_valid,
    input wire logic       tx_ready,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    ack_due_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    pkt_cause_a: assert property (pkt_valid |-> $past(rx_valid))
        else $error("char without cause");
    pkt_data_a: assert property (pkt_valid |-> pkt_data == $past(rx_data))
        else $error("char data wrong");
    gap_close_a: assert property (pkt_close && !pkt_valid |-> !$past(rx_valid))
        else $error("gap close after char");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx dropped");
    mb_cause_a: assert property (mb_valid |-> $past(req_valid))
        else $error("request without cause");
    route_cause_a: assert property (rout_valid |-> $past(rin_valid))
        else $error("route without cause");
    cover property (pkt_valid && pkt_close);
    cover property (pkt_close && !pkt_valid);
    cover property (tx_valid && tx_ready);
endmodule
bind serial_port_protocol_engine serial_engine_assertions u_chk (.clk_sys, .resetn, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .rx_valid, .rx_data, .pkt_valid, .pkt_data, .pkt_close, .req_valid,
    .mb_valid, .rin_valid, .rout_valid, .tx_ready, .tx_valid, .tx_data);

/* sim/serial_peer_model.sv */
// Attached peripheral: slow uart, mailbox data source, network activity
`timescale 1ns/1ps
module serial_peer_model (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        at_rd_valid,
    input  wire logic        at_wr_valid,
    output logic             tx_ready,
    output logic             at_rd_data_valid,
    output logic      [15:0] at_rd_data,
    output logic             at_wr_data_req,
    output logic             net_activity
);
    logic [7:0] cnt;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            {cnt, tx_ready, at_rd_data_valid, at_rd_data, at_wr_data_req, net_activity} <= '0;
        end else begin
            cnt <= cnt + 8'h01;
            tx_ready <= (cnt[1:0] == 2'h3);
            at_rd_data_valid <= at_rd_valid;
            at_rd_data <= at_rd_valid ? {8'h5a, cnt} : ~at_rd_data;
            at_wr_data_req <= at_wr_valid;
            net_activity <= (cnt[5:3] == 3'h0);
        end
    end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the protocol engine
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, rx_valid = 0;
    logic [7:0] wb_adr_i = 0, rx_data = 0, pkt_data, tx_data, mb_func, c, got8, ret_data = 0;
    logic [3:0] wb_sel_i = 4'hf, rin_len = 0, rout_len, reply_len;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic [63:0] rin_route = 0, rout_route, reply_route;
    logic [13:0] req_reg = 0;
    logic [15:0] mb_addr, at_rd_reg, at_rd_cnt, at_wr_reg, at_wr_cnt, at_rd_data, got;
    logic [15:0] mbx_waddr, mbx_wdata, mbx_raddr, b;
    logic ret_valid = 0, ret_last = 0, rin_valid = 0, req_valid = 0, req_write = 0, mb_fail = 0;
    logic wb_ack_o, pkt_valid, pkt_close, ret_ready, tx_ready, tx_valid, crc_sel, rout_valid;
    logic mb_valid, retry_go, net_activity, md_clear, at_rd_valid, at_wr_valid, mbx_we;
    logic at_rd_data_valid, at_wr_data_req, wr_seen = 0;
    int miscompares = 0, tests_run = 0, n, m;
    always #4 clk_sys = ~clk_sys;
    serial_port_protocol_engine #(.TICK_CYCLES(10)) uut (.*);
    serial_peer_model peer (.*);
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) got8 <= tx_data;
        if (at_rd_data_valid) got <= at_rd_data;
        if (at_wr_valid) wr_seen <= 1;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_sys);
    endtask
    task automatic send(input logic [7:0] ch, input logic cl);
        rx_valid <= 1; rx_data <= ch; @(posedge clk_sys);
        rx_valid <= 0; @(posedge clk_sys);
        chk({pkt_valid, pkt_data, pkt_close}, {1'b1, ch, cl}, "packet char");
    endtask
    task automatic req(input logic w, input logic [13:0] r, input logic [7:0] f);
        req_valid <= 1; req_write <= w; req_reg <= r; @(posedge clk_sys);
        req_valid <= 0; @(posedge clk_sys);
        chk({mb_valid, mb_func, mb_addr}, {1'b1, f, 16'(r + b - 1)}, "host request");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #300000;
        miscompares++;
        complete_run;
    end
    initial begin
        static logic [31:0] rv[4] = '{32'h100, 32'h640080, 32'h641004, 32'h1};
        static logic [7:0] rc[4] = '{1, 2, 3, 4}, wc[4] = '{5, 6, 15, 16};
        void'($urandom(32'h7d13d3b3));
        repeat (8) @(posedge clk_sys);
        resetn <= 1; @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin wb(0, 8'(i * 4), 0); chk(q, rv[i], "reset"); end
        wb(0, 8'h40, 0); chk(q, 0, "unmapped");
        wb(1, 8'h04, 32'h640004);
        for (int i = 0; i < 8; i++) send(8'(8'h20 + $urandom_range(94)), &i[1:0]);
        wb(1, 8'h04, 32'h640001);
        for (int i = 0; i < 3; i++) send(8'($urandom_range(8'h20, 8'hfe)), 1);
        wb(1, 8'h04, 32'h640080);
        send(8'h41, 0); send(8'h0d, 1);
        wb(1, 8'h00, 0); wb(1, 8'h04, 32'h20080);
        send(8'h0a, 0);
        n = 0; while (pkt_close !== 1'b1 && n < 100) begin @(posedge clk_sys); n++; end
        chk(n >= 10 && n < 100, 1, "gap close");
        wb(1, 8'h00, 32'h200); c = 8'(8'h20 + $urandom_range(90)); send(c, 0);
        n = 0; while (got8 !== c && n < 50) begin @(posedge clk_sys); n++; end
        chk(got8, c, "echo");
        chk(crc_sel, 0, "check sel"); wb(1, 8'h00, 32'h800); chk(crc_sel, 1, "crc sel");
        wb(1, 8'h00, 32'h4);
        for (int i = 0; i < 4; i++) begin
            b = 16'($urandom_range(40000)); n = $urandom_range(1, 8192);
            wb(1, 8'h08, {16'h64, wc[i], rc[i]}); wb(1, 8'h0c, {16'h0, b});
            req(0, 14'(n), rc[i]); req(1, 14'(n), wc[i]);
        end
        wb(1, 8'h08, 32'h21004); mb_fail <= 1; @(posedge clk_sys); mb_fail <= 0;
        n = 0; while (retry_go !== 1'b1 && n < 100) begin @(posedge clk_sys); n++; end
        chk(n >= 10 && n < 100, 1, "retry spacing");
        wb(1, 8'h00, 32'h6); wb(1, 8'h24, 32'h2); wb(1, 8'h28, 32'h3344);
        rin_len <= 3; rin_route <= {40'h0, 8'hcd, 16'($urandom)}; rin_valid <= 1;
        @(posedge clk_sys); rin_valid <= 0; @(posedge clk_sys);
        chk({rout_valid, rout_len, rout_route[31:0]}, {5'h14, 16'h3344, rin_route[15:0]},
            "route");
        wb(1, 8'h18, 32'h100002); wb(1, 8'h1c, 32'h2000100); wb(1, 8'h14, 32'h3);
        n = 0; while (at_rd_valid !== 1'b1 && n < 200) begin @(posedge clk_sys); n++; end
        chk({at_rd_cnt, at_rd_reg}, 32'h20010, "read request");
        m = 0; while (mbx_we !== 1'b1 && m < 50) begin @(posedge clk_sys); m++; end
        chk({mbx_waddr, mbx_wdata}, {16'h100, got}, "mailbox store");
        do begin @(posedge clk_sys); m++; end while (at_rd_valid !== 1'b1 && m < 100);
        chk(m >= 20 && m <= 40, 1, "interval");
        chk(wr_seen, 0, "write disabled");
        complete_run;
    end
endmodule
